// *** logic/cmd_decode.v ***
// Command decoder: classifies one 4-bit bus command for one bus side.
// Assumes the command and config type bit are sampled on the address phase.
`timescale 1ns/10ps
`include "cmd_filter_defs.vh"
module cmd_decode #(
   parameter IS_PRIMARY = 1
) (
   input  wire [3:0] cmd,
   input  wire       cfg_type1,
   output reg        claim_ok,
   output reg        master_ok
);
   // ----------------------------------------
   // Target claim and master permission table
   // ----------------------------------------
   always @* begin
      claim_ok  = 1'b0;
      master_ok = 1'b0;
      case (cmd)
         `CMD_IO_RD, `CMD_IO_WR, `CMD_MEM_RD, `CMD_MEM_WR,
         `CMD_MEM_RD_MUL, `CMD_DUAL_ADDR, `CMD_MEM_RD_LINE, `CMD_MEM_WR_INV: begin
            claim_ok  = 1'b1; // R3
            master_ok = 1'b1; // R3
         end
         // Special cycle is only ever generated, from a Type 1 config write
         `CMD_SPECIAL: begin
            claim_ok  = 1'b0; // R7
            master_ok = 1'b1; // R8
         end
         `CMD_CFG_RD: begin
            claim_ok  = (IS_PRIMARY != 0);  // R11
            master_ok = (IS_PRIMARY == 0);  // R11
         end
         `CMD_CFG_WR: begin
            // Secondary side never claims Type 0, primary never drives it
            claim_ok  = (IS_PRIMARY != 0) || cfg_type1;  // R10 R12
            master_ok = (IS_PRIMARY == 0) || cfg_type1;  // R9 R12
         end
         `CMD_INT_ACK: begin
            claim_ok  = 1'b0; // R5 R6
            master_ok = 1'b0; // R5 R6
         end
         default: begin
            claim_ok  = 1'b0; // R4
            master_ok = 1'b0; // R4
         end
      endcase
   end
endmodule // cmd_decode

// *** logic/cmd_filter_defs.vh ***
// Command codes, buffer sizes and field positions for the bridge command filter.
// Assumes inclusion by bare name from the design files.
`ifndef CMD_FILTER_DEFS_VH
`define CMD_FILTER_DEFS_VH
// ----------------------------------------
// Bus command encodings
// ----------------------------------------
`define CMD_INT_ACK     4'h0
`define CMD_SPECIAL     4'h1
`define CMD_IO_RD       4'h2
`define CMD_IO_WR       4'h3
`define CMD_RSV_4       4'h4
`define CMD_RSV_5       4'h5
`define CMD_MEM_RD      4'h6
`define CMD_MEM_WR      4'h7
`define CMD_RSV_8       4'h8
`define CMD_RSV_9       4'h9
`define CMD_CFG_RD      4'ha
`define CMD_CFG_WR      4'hb
`define CMD_MEM_RD_MUL  4'hc
`define CMD_DUAL_ADDR   4'hd
`define CMD_MEM_RD_LINE 4'he
`define CMD_MEM_WR_INV  4'hf
// ----------------------------------------
// Buffer sizing and entry layout
// ----------------------------------------
`define BUF_BYTES       128
`define BUF_WORD_BYTES  4
`define ENTRY_W         72
`define ENTRY_DATA_LSB  0
`define ENTRY_ADDR_LSB  32
`define ENTRY_CMD_LSB   64
`define ENTRY_BE_LSB    68
`endif

// *** logic/pci_bridge_command_filter.v ***
// Command filter of a two-port bus bridge with one buffer per direction.
// Assumes the address phase strobes are qualified and sampled on CLOCK.
// Contract
// [R1] Two 128-byte buffers, one upstream, one downstream.
// [R2] Buffers hold address, data, command, byte enables for reads and writes.
// [R3] Claim and initiate I/O, memory, dual address commands on both buses.
// [R4] Never drive reserved codes; ignore them as target.
// [R5] Never generate interrupt acknowledge.
// [R6] Never claim interrupt acknowledge on either bus.
// [R7] Never claim special cycles on either bus.
// [R8] Special cycles reach other buses via Type 1 config write; bridge may initiate them.
// [R9] Never generate Type 0 configuration on the primary bus.
// [R10] Ignore Type 0 configuration seen on the secondary bus.
// [R11] Config read: claimed on primary only, initiated on secondary only.
// [R12] Config write: claim any on primary, Type 1 on secondary; mirror for master.
// [R13] Ignored commands leave both buffers unchanged and raise no device select.
`timescale 1ns/10ps
`include "cmd_filter_defs.vh"
module pci_bridge_command_filter #(
   parameter DEPTH = `BUF_BYTES / `BUF_WORD_BYTES,
   parameter AW    = 5
) (
   input  wire        CLOCK,
   input  wire        RST_N,
   // Primary bus target side
   input  wire        P_ADDR_VALID,
   input  wire [3:0]  P_CMD,
   input  wire        P_CFG_TYPE1,
   input  wire [31:0] P_ADDR,
   input  wire [31:0] P_DATA,
   input  wire [3:0]  P_BE,
   output reg         P_DEVSEL,
   // Secondary bus target side
   input  wire        S_ADDR_VALID,
   input  wire [3:0]  S_CMD,
   input  wire        S_CFG_TYPE1,
   input  wire [31:0] S_ADDR,
   input  wire [31:0] S_DATA,
   input  wire [3:0]  S_BE,
   output reg         S_DEVSEL,
   // Downstream buffer drain, mastering the secondary bus
   input  wire        S_MASTER_POP,
   output wire        S_MASTER_VALID,
   output reg  [3:0]  S_MASTER_CMD,
   output reg  [31:0] S_MASTER_ADDR,
   output reg  [31:0] S_MASTER_DATA,
   output reg  [3:0]  S_MASTER_BE,
   output reg         S_MASTER_GO,
   // Upstream buffer drain, mastering the primary bus
   input  wire        P_MASTER_POP,
   output wire        P_MASTER_VALID,
   output reg  [3:0]  P_MASTER_CMD,
   output reg  [31:0] P_MASTER_ADDR,
   output reg  [31:0] P_MASTER_DATA,
   output reg  [3:0]  P_MASTER_BE,
   output reg         P_MASTER_GO,
   // Buffer room, so the target side can retry instead of claiming
   output wire        DOWN_ROOM,
   output wire        UP_ROOM
);
   wire            p_claim_ok;
   wire            p_master_ok;
   wire            s_claim_ok;
   wire            s_master_ok;
   wire            down_push;
   wire            up_push;
   wire [`ENTRY_W-1:0] down_in;
   wire [`ENTRY_W-1:0] up_in;
   wire [`ENTRY_W-1:0] down_head;
   wire [`ENTRY_W-1:0] up_head;
   wire            down_can_push;
   wire            up_can_push;
   wire            down_can_pop;
   wire            up_can_pop;
   reg             down_pend_q;
   reg             up_pend_q;
   reg             down_popped_q;
   reg             up_popped_q;
   // ----------------------------------------
   // Target side decode for each bus
   // ----------------------------------------
   cmd_decode #(.IS_PRIMARY(1)) u_p_target (
      .cmd       (P_CMD),
      .cfg_type1 (P_CFG_TYPE1),
      .claim_ok  (p_claim_ok),
      .master_ok ()
   );
   cmd_decode #(.IS_PRIMARY(0)) u_s_target (
      .cmd       (S_CMD),
      .cfg_type1 (S_CFG_TYPE1),
      .claim_ok  (s_claim_ok),
      .master_ok ()
   );
   // Master side checks the command actually leaving each buffer
   cmd_decode #(.IS_PRIMARY(0)) u_s_master (
      .cmd       (down_head[`ENTRY_CMD_LSB +: 4]),
      .cfg_type1 (down_head[`ENTRY_ADDR_LSB]),
      .claim_ok  (),
      .master_ok (s_master_ok)
   );
   cmd_decode #(.IS_PRIMARY(1)) u_p_master (
      .cmd       (up_head[`ENTRY_CMD_LSB +: 4]),
      .cfg_type1 (up_head[`ENTRY_ADDR_LSB]),
      .claim_ok  (),
      .master_ok (p_master_ok)
   );
   // ----------------------------------------
   // Buffer writes only on a claimed command
   // ----------------------------------------
   // Refusing on a full buffer keeps the entry intact instead of dropping it
   assign down_push = P_ADDR_VALID && p_claim_ok && down_can_push; // R13
   assign up_push   = S_ADDR_VALID && s_claim_ok && up_can_push;   // R13
   assign down_in = {P_BE, P_CMD, P_ADDR, P_DATA}; // R2
   assign up_in   = {S_BE, S_CMD, S_ADDR, S_DATA}; // R2
   assign DOWN_ROOM = down_can_push;
   assign UP_ROOM   = up_can_push;
   txn_buffer #(.W(`ENTRY_W), .DEPTH(DEPTH), .AW(AW)) u_down_buf ( // R1
      .clk       (CLOCK),
      .rst_n     (RST_N),
      .push      (down_push),
      .push_data (down_in),
      .can_push  (down_can_push),
      .pop       (S_MASTER_POP && !down_pend_q),
      .pop_data  (down_head),
      .can_pop   (down_can_pop)
   );
   txn_buffer #(.W(`ENTRY_W), .DEPTH(DEPTH), .AW(AW)) u_up_buf ( // R1
      .clk       (CLOCK),
      .rst_n     (RST_N),
      .push      (up_push),
      .push_data (up_in),
      .can_push  (up_can_push),
      .pop       (P_MASTER_POP && !up_pend_q),
      .pop_data  (up_head),
      .can_pop   (up_can_pop)
   );
   // ----------------------------------------
   // Device select: asserted one cycle after a claimed address phase
   // ----------------------------------------
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         P_DEVSEL <= 1'b0;
         S_DEVSEL <= 1'b0;
      end else begin
         P_DEVSEL <= down_push; // R4 R6 R7 R13
         S_DEVSEL <= up_push;   // R10 R12 R13
      end
   end
   // ----------------------------------------
   // Drain: a pop loads the head, next cycle it is checked and handed out
   // ----------------------------------------
   assign S_MASTER_VALID = down_can_pop && !down_pend_q;
   assign P_MASTER_VALID = up_can_pop && !up_pend_q;
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         down_popped_q <= 1'b0;
         up_popped_q   <= 1'b0;
         down_pend_q   <= 1'b0;
         up_pend_q     <= 1'b0;
      end else begin
         down_popped_q <= S_MASTER_POP && S_MASTER_VALID;
         up_popped_q   <= P_MASTER_POP && P_MASTER_VALID;
         down_pend_q   <= S_MASTER_POP && S_MASTER_VALID;
         up_pend_q     <= P_MASTER_POP && P_MASTER_VALID;
      end
   end
   // Forbidden commands are dropped here, never driven on the far bus
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         S_MASTER_GO   <= 1'b0;
         S_MASTER_CMD  <= 4'h0;
         S_MASTER_ADDR <= 32'h0000_0000;
         S_MASTER_DATA <= 32'h0000_0000;
         S_MASTER_BE   <= 4'h0;
      end else begin
         S_MASTER_GO <= down_popped_q && s_master_ok; // R4 R5 R11
         if (down_popped_q && s_master_ok) begin
            S_MASTER_CMD  <= down_head[`ENTRY_CMD_LSB +: 4];
            S_MASTER_ADDR <= down_head[`ENTRY_ADDR_LSB +: 32];
            S_MASTER_DATA <= down_head[`ENTRY_DATA_LSB +: 32];
            S_MASTER_BE   <= down_head[`ENTRY_BE_LSB +: 4];
         end
      end
   end
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         P_MASTER_GO   <= 1'b0;
         P_MASTER_CMD  <= 4'h0;
         P_MASTER_ADDR <= 32'h0000_0000;
         P_MASTER_DATA <= 32'h0000_0000;
         P_MASTER_BE   <= 4'h0;
      end else begin
         P_MASTER_GO <= up_popped_q && p_master_ok; // R5 R9 R11 R12
         if (up_popped_q && p_master_ok) begin
            P_MASTER_CMD  <= up_head[`ENTRY_CMD_LSB +: 4];
            P_MASTER_ADDR <= up_head[`ENTRY_ADDR_LSB +: 32];
            P_MASTER_DATA <= up_head[`ENTRY_DATA_LSB +: 32];
            P_MASTER_BE   <= up_head[`ENTRY_BE_LSB +: 4];
         end
      end
   end
endmodule // pci_bridge_command_filter

// *** logic/txn_buffer.v ***
// Transaction buffer for one direction: entries of data, address, command, byte enables.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/10ps
`include "cmd_filter_defs.vh"
module txn_buffer #(
   parameter W     = `ENTRY_W,
   parameter DEPTH = `BUF_BYTES / `BUF_WORD_BYTES,
   parameter AW    = 5
) (
   input  wire          clk,
   input  wire          rst_n,
   input  wire          push,
   input  wire [W-1:0]  push_data,
   output wire          can_push,
   input  wire          pop,
   output reg  [W-1:0]  pop_data,
   output wire          can_pop
);
   reg [W-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0]   cnt_q;
   wire do_push;
   wire do_pop;
   // ----------------------------------------
   // Flags; a full buffer refuses writes
   // ----------------------------------------
   assign can_push = (cnt_q != DEPTH[AW:0]);
   assign can_pop  = (cnt_q != {(AW+1){1'b0}});
   assign do_push  = push && can_push;
   assign do_pop   = pop && can_pop;
   // Storage has no reset; only pointers define contents
   always @(posedge clk) begin
      if (do_push) begin
         mem[wr_q] <= push_data;
      end
   end
   // Pointers, count and registered head
   always @(posedge clk) begin
      if (!rst_n) begin
         wr_q     <= {AW{1'b0}};
         rd_q     <= {AW{1'b0}};
         cnt_q    <= {(AW+1){1'b0}};
         pop_data <= {W{1'b0}};
      end else begin
         if (do_push) begin
            wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
         end
         if (do_pop) begin
            pop_data <= mem[rd_q];
            rd_q     <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
         end
         if (do_push && !do_pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (do_pop && !do_push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // txn_buffer

// *** tb/bridge_filter_assertions.sv ***
// Port assertions for the bridge command filter.
// Assumes it is bound onto the filter top; one clock domain.
`timescale 1ns/10ps
module bridge_filter_assertions (
   input wire logic        CLOCK,
   input wire logic        RST_N,
   input wire logic        P_ADDR_VALID,
   input wire logic [3:0]  P_CMD,
   input wire logic        P_DEVSEL,
   input wire logic        S_ADDR_VALID,
   input wire logic [3:0]  S_CMD,
   input wire logic        S_CFG_TYPE1,
   input wire logic        S_DEVSEL,
   input wire logic        DOWN_ROOM,
   input wire logic        UP_ROOM,
   input wire logic        S_MASTER_POP,
   input wire logic        S_MASTER_GO,
   input wire logic [3:0]  S_MASTER_CMD,
   input wire logic        P_MASTER_POP,
   input wire logic        P_MASTER_GO,
   input wire logic [3:0]  P_MASTER_CMD,
   input wire logic [31:0] P_MASTER_ADDR
);
   // Claimable sets; secondary takes config write only as Type 1
   wire p_ok = P_CMD inside {4'h2, 4'h3, 4'h6, 4'h7, [4'ha:4'hf]};
   wire s_ok = (S_CMD inside {4'h2, 4'h3, 4'h6, 4'h7, [4'hc:4'hf]}) |
               ((S_CMD == 4'hb) & S_CFG_TYPE1);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   p_claim_a: assert property (
      P_ADDR_VALID && p_ok && DOWN_ROOM |=> P_DEVSEL) else $error("primary claim missing");
   p_ignore_a: assert property (
      P_ADDR_VALID && !p_ok |=> !P_DEVSEL) else $error("primary claimed bad command");
   s_claim_a: assert property (
      S_ADDR_VALID && s_ok && UP_ROOM |=> S_DEVSEL) else $error("secondary claim missing");
   s_ignore_a: assert property (
      S_ADDR_VALID && !s_ok |=> !S_DEVSEL) else $error("secondary claimed bad command");
   full_refuse_a: assert property (
      P_ADDR_VALID && !DOWN_ROOM |=> !P_DEVSEL) else $error("claim with full buffer");
   devsel_cause_a: assert property (
      (P_DEVSEL |-> $past(P_ADDR_VALID)) and (S_DEVSEL |-> $past(S_ADDR_VALID)))
      else $error("select without address phase");
   go_latency_a: assert property (
      (S_MASTER_GO |-> $past(S_MASTER_POP, 2)) and (P_MASTER_GO |-> $past(P_MASTER_POP, 2)))
      else $error("go without pop");
   s_master_cmd_a: assert property (
      S_MASTER_GO |-> !(S_MASTER_CMD inside {4'h0, 4'h4, 4'h5, 4'h8, 4'h9}))
      else $error("bad secondary master command");
   p_master_cmd_a: assert property (
      P_MASTER_GO |-> !(P_MASTER_CMD inside {4'h0, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha}) &&
      (P_MASTER_CMD != 4'hb || P_MASTER_ADDR[0])) else $error("bad primary master command");
endmodule // bridge_filter_assertions

// *** tb/drain_model.sv ***
// Far-side model that drains one direction buffer of the bridge.
// Assumes VALID is combinational and every pop is taken on clk.
`timescale 1ns/10ps
module drain_model (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic en,
   input  wire logic valid,
   output reg        pop
);
   // Never pops two cycles running, so pops stay at least two cycles apart
   always @(posedge clk) begin
      if (!rst_n)
         pop <= 1'b0;
      else
         pop <= en & valid & ~pop;
   end
endmodule // drain_model

// *** tb/test_pci_bridge_command_filter.sv ***
// Self-checking bench for the bridge command filter.
// Assumes drain models on both master sides and the bound checker.
`timescale 1ns/10ps
module test_pci_bridge_command_filter;
   reg         CLOCK, RST_N, P_ADDR_VALID, P_CFG_TYPE1, S_ADDR_VALID, S_CFG_TYPE1, s_en, p_en;
   reg  [3:0]  P_CMD, P_BE, S_CMD, S_BE;
   reg  [31:0] P_ADDR, P_DATA, S_ADDR, S_DATA;
   wire        P_DEVSEL, S_DEVSEL, DOWN_ROOM, UP_ROOM, S_MASTER_POP, P_MASTER_POP;
   wire        S_MASTER_VALID, S_MASTER_GO, P_MASTER_VALID, P_MASTER_GO;
   wire [3:0]  S_MASTER_CMD, S_MASTER_BE, P_MASTER_CMD, P_MASTER_BE;
   wire [31:0] S_MASTER_ADDR, S_MASTER_DATA, P_MASTER_ADDR, P_MASTER_DATA;
   integer     failures, comparisons, i, t;
   pci_bridge_command_filter u_pci_bridge_command_filter (.CLOCK(CLOCK), .RST_N(RST_N),
      .P_ADDR_VALID(P_ADDR_VALID), .P_CMD(P_CMD), .P_CFG_TYPE1(P_CFG_TYPE1), .P_ADDR(P_ADDR),
      .P_DATA(P_DATA), .P_BE(P_BE), .P_DEVSEL(P_DEVSEL), .S_ADDR_VALID(S_ADDR_VALID),
      .S_CMD(S_CMD), .S_CFG_TYPE1(S_CFG_TYPE1), .S_ADDR(S_ADDR), .S_DATA(S_DATA), .S_BE(S_BE),
      .S_DEVSEL(S_DEVSEL), .S_MASTER_POP(S_MASTER_POP), .S_MASTER_VALID(S_MASTER_VALID),
      .S_MASTER_CMD(S_MASTER_CMD), .S_MASTER_ADDR(S_MASTER_ADDR), .S_MASTER_DATA(S_MASTER_DATA),
      .S_MASTER_BE(S_MASTER_BE), .S_MASTER_GO(S_MASTER_GO), .P_MASTER_POP(P_MASTER_POP),
      .P_MASTER_VALID(P_MASTER_VALID), .P_MASTER_CMD(P_MASTER_CMD),
      .P_MASTER_ADDR(P_MASTER_ADDR), .P_MASTER_DATA(P_MASTER_DATA), .P_MASTER_BE(P_MASTER_BE),
      .P_MASTER_GO(P_MASTER_GO), .DOWN_ROOM(DOWN_ROOM), .UP_ROOM(UP_ROOM));
   drain_model u_drain_model (.clk(CLOCK), .rst_n(RST_N), .en(s_en),
      .valid(S_MASTER_VALID), .pop(S_MASTER_POP));
   drain_model u_drain_model_up (.clk(CLOCK), .rst_n(RST_N), .en(p_en),
      .valid(P_MASTER_VALID), .pop(P_MASTER_POP));
   // Clock at 100 ns
   initial begin
      CLOCK = 1'b0;
      forever #50 CLOCK = ~CLOCK;
   end
   task check(input string what, input [31:0] exp, input [31:0] got);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   // One address phase; returns just after the edge that answers it
   task send(input bit sec, input [3:0] c, input t1, input [31:0] a);
      @(posedge CLOCK);
      if (sec) begin
         S_ADDR_VALID <= 1'b1; S_CMD <= c; S_CFG_TYPE1 <= t1; S_ADDR <= a; S_DATA <= ~a; S_BE <= c;
      end else begin
         P_ADDR_VALID <= 1'b1; P_CMD <= c; P_CFG_TYPE1 <= t1; P_ADDR <= a; P_DATA <= ~a; P_BE <= c;
      end
      @(posedge CLOCK);
      P_ADDR_VALID <= 1'b0;
      S_ADDR_VALID <= 1'b0;
      #1;
   endtask
   // Waits a bounded time for the far master strobe, then judges its fields
   task wait_go(input bit up, input [3:0] c, input [31:0] a, input [31:0] d);
      integer n;
      n = 0;
      do begin
         @(posedge CLOCK); #1; n = n + 1;
      end while ((up ? P_MASTER_GO : S_MASTER_GO) !== 1'b1 && n < 12);
      check("go", 1, up ? P_MASTER_GO : S_MASTER_GO);
      check("cmd", c, up ? P_MASTER_CMD : S_MASTER_CMD);
      check("addr", a, up ? P_MASTER_ADDR : S_MASTER_ADDR);
      check("data", d, up ? P_MASTER_DATA : S_MASTER_DATA);
      check("be", c, up ? P_MASTER_BE : S_MASTER_BE);
   endtask
   // Every code on the primary bus; claimed ones must reach the secondary
   task t_primary;
      for (i = 0; i < 16; i = i + 1) begin
         send(1'b0, i[3:0], 1'b0, 32'h1000 + i * 4);
         check("p_devsel", 16'hfccc >> i & 1, P_DEVSEL);
         if (16'hfccc >> i & 1) wait_go(1'b0, i[3:0], 32'h1000 + i * 4, ~(32'h1000 + i * 4));
         else check("s_valid", 0, S_MASTER_VALID);
      end
   endtask
   // Every code on the secondary bus, both config types
   task t_secondary;
      for (t = 0; t < 2; t = t + 1)
         for (i = 0; i < 16; i = i + 1) begin
            // Address bit 0 carries the config type, as the master side reads it
            send(1'b1, i[3:0], t[0], 32'h2000 + i * 4 + t);
            check("s_devsel", (16'hf0cc | t << 11) >> i & 1, S_DEVSEL);
            if ((16'hf0cc | t << 11) >> i & 1)
               wait_go(1'b1, i[3:0], 32'h2000 + i * 4 + t, ~(32'h2000 + i * 4 + t));
            else check("p_valid", 0, P_MASTER_VALID);
         end
   endtask
   // Type 1 claim whose stored address marks Type 0: queued, but never mastered upstream
   task t_drop;
      send(1'b1, 4'hb, 1'b1, 32'h3000);
      check("drop_devsel", 1, S_DEVSEL);
      for (i = 0; i < 6; i = i + 1) begin
         @(posedge CLOCK);
         #1;
         check("drop_go", 0, P_MASTER_GO);
      end
      check("drop_valid", 0, P_MASTER_VALID);
   endtask
   // Fill the downstream buffer with a stalled drain, then empty it in order
   task t_fill;
      @(posedge CLOCK) s_en <= 1'b0;
      for (i = 0; i < 32; i = i + 1) begin
         send(1'b0, 4'h7, 1'b0, i * 4);
         check("fill_devsel", 1, P_DEVSEL);
      end
      check("down_room", 0, DOWN_ROOM);
      send(1'b0, 4'h6, 1'b0, 32'h80);
      check("full_devsel", 0, P_DEVSEL);
      @(posedge CLOCK) s_en <= 1'b1;
      for (i = 0; i < 32; i = i + 1) wait_go(1'b0, 4'h7, i * 4, ~(i * 4));
      repeat (3) @(posedge CLOCK);
      #1 check("empty", 0, S_MASTER_VALID);
   endtask
   task print_verdict;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Watchdog, far beyond the roughly 360 cycles the tests need
   initial begin
      #500000 failures = failures + 1;
      print_verdict;
   end
   initial begin
      {RST_N, P_ADDR_VALID, P_CFG_TYPE1, S_ADDR_VALID, S_CFG_TYPE1} = 5'h00;
      {P_CMD, P_BE, S_CMD, S_BE, P_ADDR, P_DATA, S_ADDR, S_DATA} = 144'h0;
      {s_en, p_en} = 2'h3;
      failures = 0;
      comparisons = 0;
      repeat (3) @(posedge CLOCK);
      RST_N <= 1'b1;
      @(posedge CLOCK);
      #1 check("room", 1, DOWN_ROOM & UP_ROOM & ~S_MASTER_VALID & ~P_MASTER_VALID);
      t_primary;
      t_secondary;
      t_drop;
      t_fill;
      print_verdict;
   end
endmodule // test_pci_bridge_command_filter
bind pci_bridge_command_filter bridge_filter_assertions u_chk (.CLOCK(CLOCK), .RST_N(RST_N),
   .P_ADDR_VALID(P_ADDR_VALID), .P_CMD(P_CMD), .P_DEVSEL(P_DEVSEL),
   .S_ADDR_VALID(S_ADDR_VALID), .S_CMD(S_CMD), .S_CFG_TYPE1(S_CFG_TYPE1),
   .S_DEVSEL(S_DEVSEL), .DOWN_ROOM(DOWN_ROOM), .UP_ROOM(UP_ROOM),
   .S_MASTER_POP(S_MASTER_POP), .S_MASTER_GO(S_MASTER_GO), .S_MASTER_CMD(S_MASTER_CMD),
   .P_MASTER_POP(P_MASTER_POP), .P_MASTER_GO(P_MASTER_GO), .P_MASTER_CMD(P_MASTER_CMD),
   .P_MASTER_ADDR(P_MASTER_ADDR));
